//--- rtl/rsd_pkg.sv
// Shared constants for the reference switchover, divider and spread block
package rsd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PLL0 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_ODIV0 = 8'h18;
  localparam logic [7:0] OFF_SSC = 8'h28;
  localparam logic [7:0] OFF_SD_LO = 8'h2C;
  localparam logic [7:0] OFF_SD_HI = 8'h30;
  localparam logic [7:0] OFF_MTOT0 = 8'h34;
  localparam logic [7:0] OFF_MOD = 8'h44;
  // Field positions
  localparam int CTRL_SM_LSB = 0;
  localparam int CTRL_PRIM_BIT = 2;
  localparam int CTRL_XCLK_BIT = 3;
  localparam int PLL_N_LSB = 8;
  localparam int PLL_A_LSB = 20;
  localparam int ODIV_PM_BIT = 7;
  localparam int ODIV_OEM_LSB = 8;
  localparam int SSC_NSSC_LSB = 4;
  localparam int SSC_OFS_LSB = 8;
  localparam int SSC_LSB_RANDOMIZE_ENABLE_BIT = 16;
  localparam int SSC_X2_BIT = 17;
  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PLL_RST = 32'h0000_0000;
  localparam logic [31:0] ODIV_RST = 32'h0000_007F;
  localparam logic [31:0] SSC_RST = 32'h0000_0000;
  localparam logic [7:0] LFSR_RST = 8'h01;
  // Counts
  localparam logic [1:0] ABSENT_EDGES = 2'h2;
  localparam logic [4:0] STEP_ADD = 5'h02;
  localparam logic [6:0] Q_ALL_ONES = 7'h7F;
  localparam int NUM_PLL = 4;
  localparam int NUM_BANK = 4;
  localparam int NUM_SD = 12;
  // Disabled output levels
  localparam logic [1:0] OEM_LOW = 2'h0;
  localparam logic [1:0] OEM_HIGH = 2'h1;
endpackage

//--- rtl/rsd_ss_if.sv
// Configuration and result bundle between control core and modulator
`timescale 1ns/1ps
interface rsd_ss_if;
  logic [3:0] tssc; // Step period code
  logic [2:0] nssc; // Quadrant sample code
  logic [5:0] offset; // Spread offset
  logic dither; // LSB randomize enable
  logic x2; // Amplitude double
  logic [47:0] sd; // Twelve 4-bit delta samples
  logic pfd_tick; // One pulse per phase detector cycle
  logic [9:0] point; // Current modulation point, signed
  logic active; // Modulator running
  modport ctl (output tssc, nssc, offset, dither, x2, sd, pfd_tick, input point, active);
  modport modu (input tssc, nssc, offset, dither, x2, sd, pfd_tick, output point, active);
endinterface

//--- rtl/rsd_ssc_mod.sv
// Delta-sample spread-spectrum modulator for the first PLL
`timescale 1ns/1ps
module rsd_ssc_mod (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Modulator bundle
  rsd_ss_if.modu ss
);
  logic [4:0] step_cnt_reg; // Phase detector cycles in this step
  logic [3:0] idx_reg; // Sample index within quadrant
  logic [1:0] quad_reg; // Quadrant number
  logic [7:0] acc_reg; // Accumulated delta magnitude
  logic [7:0] lfsr_reg; // Dither source
  logic [9:0] point_reg; // Output point
  logic [3:0] n_samp; // Samples per quadrant
  logic step;
  logic [3:0] fwd_s;
  logic [3:0] rev_s;
  logic [9:0] scaled;
  logic [9:0] raw;

  // Fetch one 4-bit delta sample by index
  function automatic logic [3:0] sd_at(input logic [47:0] v, input logic [3:0] i);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < rsd_pkg::NUM_SD; k++) begin
      if (i == 4'(k)) begin
        r = v[k*4 +: 4];
      end
    end
    return r;
  endfunction

  assign ss.active = (ss.tssc != 4'h0);
  assign n_samp = {ss.nssc, 1'b0};
  assign step = ss.active && ss.pfd_tick &&
    (step_cnt_reg == 5'({1'b0, ss.tssc} + rsd_pkg::STEP_ADD - 5'h01));
  assign fwd_s = sd_at(ss.sd, idx_reg);
  assign rev_s = sd_at(ss.sd, 4'(n_samp - 4'h1 - idx_reg));

  // Step timer in phase detector cycles
  always_ff @(posedge clk) begin
    if (!nrst || !ss.active) begin
      step_cnt_reg <= 5'h00;
    end else if (step) begin
      step_cnt_reg <= 5'h00;
    end else if (ss.pfd_tick) begin
      step_cnt_reg <= 5'(step_cnt_reg + 5'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !ss.active) begin
      idx_reg <= 4'h0;
      quad_reg <= 2'h0;
    end else if (step) begin
      if (idx_reg >= 4'(n_samp - 4'h1)) begin
        idx_reg <= 4'h0;
        quad_reg <= 2'(quad_reg + 2'h1);
      end else begin
        idx_reg <= 4'(idx_reg + 4'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !ss.active) begin
      acc_reg <= 8'h00;
    end else if (step) begin
      // Rising halves walk forward, falling halves walk back
      if (!quad_reg[0]) begin
        acc_reg <= 8'(acc_reg + {4'h0, fwd_s});
      end else begin
        acc_reg <= 8'(acc_reg - {4'h0, rev_s});
      end
    end
  end

  // Free-running dither source
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lfsr_reg <= rsd_pkg::LFSR_RST;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
  end

  assign scaled = ss.x2 ? {1'b0, acc_reg, 1'b0} : {2'b00, acc_reg};
  assign raw = quad_reg[1] ? 10'({4'h0, ss.offset} - scaled) :
    10'({4'h0, ss.offset} + scaled);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      point_reg <= 10'h000;
    end else begin
      point_reg <= {raw[9:1], raw[0] ^ (ss.dither & lfsr_reg[0])};
    end
  end
  assign ss.point = point_reg;
endmodule

//--- rtl/rsd_top.sv
// Reference switchover, PLL divider settings and output dividers with register bus
//
// Function
// - Manual mode follows the reference select pin
// - Manual reference change never glitches output
// - Auto: primary silent two secondary cycles
// - Revertive mode returns to recovered primary
// - 7-bit reference, 12-bit feedback per PLL
// - Output divider decode from count, prescale
// - Disabled divider drives chosen idle level
// - Spread active when step code nonzero
// - Step lasts code plus two cycles
// - Quadrant uses twice sample code samples
// - Four mirrored quadrants share delta samples
// - Period is four times samples times step
// - Offset zero center, nonzero down spread
// - Waveform starts at offset, adds deltas
// - Dither randomizes modulator input LSB
// - Amplitude double bit doubles delta sum
// - Primary source bit picks primary input
// - Auto switchover only with clocked crystal pin
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module rsd_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Reference pins
  input wire logic xin_ref,
  input wire logic clkin,
  input wire logic ref_select_pin,
  // Selected reference and PLL settings
  output logic ref_out,
  output logic pfd_tick,
  output logic [3:0][6:0] pll_ref_div,
  output logic [3:0][13:0] pll_fb_total,
  output logic [9:0] ss_point,
  // Output banks
  input wire logic [3:0] bank_clk_in,
  output logic [3:0] bank_out,
  output logic [3:0] bank_out_en_n
);
  // Software registers
  logic [31:0] ctrl_reg;
  logic [3:0][31:0] pll_reg;
  logic [3:0][31:0] odiv_reg;
  logic [31:0] ssc_reg;
  logic [47:0] sd_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  // Pin synchronisers, first stage read only by the second
  logic xin_s1, xin_s2, xin_q;
  logic clk_s1, clk_s2, clk_q;
  logic sel_s1, sel_s2;
  logic [3:0] bank_s1, bank_s2, bank_q;
  // Switchover state
  logic [1:0] absent_cnt_reg;
  logic want_sec_reg;
  logic on_sec_reg;
  logic ref_out_reg;
  logic ref_q;
  logic [6:0] pfd_cnt_reg;
  logic pfd_reg;
  // Output divider state
  logic [3:0][7:0] div_cnt_reg;
  logic [3:0] div_out_reg;
  logic [3:0] bank_out_reg;
  logic [3:0] bank_en_n_reg;
  // Decoded views
  logic [1:0] switch_mode_field;
  logic primary_source_bit;
  logic xin_is_clock;
  logic prim_s, sec_s, prim_q, sec_q;
  logic prim_edge, sec_rise;
  logic prim_absent;
  logic auto_ok;
  logic wr_en, rd_en;

  rsd_ss_if ss ();

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] lane_wr(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] fb_total(input logic [31:0] p, input logic first);
    logic [11:0] n;
    logic [3:0] a;
    logic [13:0] m;
    n = p[rsd_pkg::PLL_N_LSB +: 12];
    a = p[rsd_pkg::PLL_A_LSB +: 4];
    m = {2'b00, n};
    if (first) begin
      m = (a != 4'h0) ? 14'({n, 1'b0} + {10'h000, a} + 14'h0001) : 14'({n, 1'b0});
    end
    return m;
  endfunction

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;

  // Bus acknowledge, one cycle per access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  // Register writes, each register one word
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= rsd_pkg::CTRL_RST;
      pll_reg <= {rsd_pkg::NUM_PLL{rsd_pkg::PLL_RST}};
      odiv_reg <= {rsd_pkg::NUM_BANK{rsd_pkg::ODIV_RST}};
      ssc_reg <= rsd_pkg::SSC_RST;
      sd_reg <= 48'h0000_0000_0000;
    end else if (wr_en) begin
      if (wb_adr_i == rsd_pkg::OFF_CTRL) begin
        ctrl_reg <= lane_wr(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_000F;
      end
      for (int i = 0; i < rsd_pkg::NUM_PLL; i++) begin
        if (wb_adr_i == 8'(rsd_pkg::OFF_PLL0 + 8'(4 * i))) begin
          pll_reg[i] <= lane_wr(pll_reg[i], wb_dat_i, wb_sel_i) & 32'h00FF_FF7F;
        end
      end
      for (int i = 0; i < rsd_pkg::NUM_BANK; i++) begin
        if (wb_adr_i == 8'(rsd_pkg::OFF_ODIV0 + 8'(4 * i))) begin
          odiv_reg[i] <= lane_wr(odiv_reg[i], wb_dat_i, wb_sel_i) & 32'h0000_03FF;
        end
      end
      if (wb_adr_i == rsd_pkg::OFF_SSC) begin
        ssc_reg <= lane_wr(ssc_reg, wb_dat_i, wb_sel_i) & 32'h0003_3F7F;
      end
      if (wb_adr_i == rsd_pkg::OFF_SD_LO) begin
        sd_reg[31:0] <= lane_wr(sd_reg[31:0], wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == rsd_pkg::OFF_SD_HI) begin
        sd_reg[47:32] <= 16'(lane_wr({16'h0000, sd_reg[47:32]}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // Read data, unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdat_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      rdat_reg <= 32'h0000_0000;
      case (wb_adr_i)
        rsd_pkg::OFF_CTRL: rdat_reg <= ctrl_reg;
        rsd_pkg::OFF_STAT: rdat_reg <= {28'h0000000, ss.active, prim_absent,
                                        want_sec_reg, on_sec_reg};
        rsd_pkg::OFF_SSC: rdat_reg <= ssc_reg;
        rsd_pkg::OFF_SD_LO: rdat_reg <= sd_reg[31:0];
        rsd_pkg::OFF_SD_HI: rdat_reg <= {16'h0000, sd_reg[47:32]};
        rsd_pkg::OFF_MOD: rdat_reg <= {22'h000000, ss.point};
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_adr_i == 8'(rsd_pkg::OFF_PLL0 + 8'(4 * i))) begin
              rdat_reg <= pll_reg[i];
            end
            if (wb_adr_i == 8'(rsd_pkg::OFF_ODIV0 + 8'(4 * i))) begin
              rdat_reg <= odiv_reg[i];
            end
            if (wb_adr_i == 8'(rsd_pkg::OFF_MTOT0 + 8'(4 * i))) begin
              rdat_reg <= {18'h00000, fb_total(pll_reg[i], i == 0)};
            end
          end
        end
      endcase
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Two-stage synchronisers plus a history stage for edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {xin_s1, xin_s2, xin_q} <= 3'b000;
      {clk_s1, clk_s2, clk_q} <= 3'b000;
      {sel_s1, sel_s2} <= 2'b00;
      bank_s1 <= 4'h0;
      bank_s2 <= 4'h0;
      bank_q <= 4'h0;
    end else begin
      {xin_s1, xin_s2, xin_q} <= {xin_ref, xin_s1, xin_s2};
      {clk_s1, clk_s2, clk_q} <= {clkin, clk_s1, clk_s2};
      {sel_s1, sel_s2} <= {ref_select_pin, sel_s1};
      bank_s1 <= bank_clk_in;
      bank_s2 <= bank_s1;
      bank_q <= bank_s2;
    end
  end

  assign switch_mode_field = ctrl_reg[rsd_pkg::CTRL_SM_LSB +: 2];
  assign primary_source_bit = ctrl_reg[rsd_pkg::CTRL_PRIM_BIT];
  assign xin_is_clock = ctrl_reg[rsd_pkg::CTRL_XCLK_BIT];
  // primary and secondary by source bit
  assign prim_s = primary_source_bit ? clk_s2 : xin_s2;
  assign sec_s = primary_source_bit ? xin_s2 : clk_s2;
  assign prim_q = primary_source_bit ? clk_q : xin_q;
  assign sec_q = primary_source_bit ? xin_q : clk_q;
  assign prim_edge = prim_s ^ prim_q;
  assign sec_rise = sec_s & ~sec_q;
  assign prim_absent = (absent_cnt_reg == rsd_pkg::ABSENT_EDGES);
  // auto only for clocked crystal pin as primary
  assign auto_ok = switch_mode_field[1] && xin_is_clock && !primary_source_bit;

  always_ff @(posedge clk) begin
    if (!nrst || prim_edge) begin
      absent_cnt_reg <= 2'h0;
    end else if (sec_rise && !prim_absent) begin
      absent_cnt_reg <= 2'(absent_cnt_reg + 2'h1);
    end
  end

  // Wanted reference per switch mode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      want_sec_reg <= 1'b0;
    end else if (!switch_mode_field[1]) begin
      want_sec_reg <= sel_s2;
    end else if (!auto_ok) begin
      want_sec_reg <= 1'b0;
    end else if (prim_absent) begin
      want_sec_reg <= 1'b1;
    end else if (switch_mode_field[0]) begin
      want_sec_reg <= 1'b0;
    end
  end

  // swap only while both references low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      on_sec_reg <= 1'b0;
    end else if (!prim_s && !sec_s) begin
      on_sec_reg <= want_sec_reg;
    end
  end

  // Selected reference, registered to keep it clean
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_out_reg <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      ref_out_reg <= on_sec_reg ? sec_s : prim_s;
      ref_q <= ref_out_reg;
    end
  end
  assign ref_out = ref_out_reg;

  // phase detector rate is reference over divider
  always_ff @(posedge clk) begin
    if (!nrst || pll_reg[0][6:0] == 7'h00) begin
      pfd_cnt_reg <= 7'h00;
      pfd_reg <= 1'b0;
    end else if (ref_out_reg && !ref_q) begin
      pfd_reg <= (pfd_cnt_reg == 7'(pll_reg[0][6:0] - 7'h01));
      pfd_cnt_reg <= (pfd_cnt_reg == 7'(pll_reg[0][6:0] - 7'h01)) ? 7'h00 :
        7'(pfd_cnt_reg + 7'h01);
    end else begin
      pfd_reg <= 1'b0;
    end
  end
  assign pfd_tick = pfd_reg;

  // PLL settings presented to the analog side
  always_comb begin
    for (int i = 0; i < rsd_pkg::NUM_PLL; i++) begin
      pll_ref_div[i] = pll_reg[i][6:0];
      pll_fb_total[i] = fb_total(pll_reg[i], i == 0);
    end
  end

  // Modulator configuration
  assign ss.tssc = ssc_reg[3:0];
  assign ss.nssc = ssc_reg[rsd_pkg::SSC_NSSC_LSB +: 3];
  assign ss.offset = ssc_reg[rsd_pkg::SSC_OFS_LSB +: 6];
  assign ss.dither = ssc_reg[rsd_pkg::SSC_LSB_RANDOMIZE_ENABLE_BIT];
  assign ss.x2 = ssc_reg[rsd_pkg::SSC_X2_BIT];
  assign ss.sd = sd_reg;
  assign ss.pfd_tick = pfd_reg;
  assign ss_point = ss.point;

  rsd_ssc_mod u_mod (
    .clk(clk),
    .nrst(nrst),
    .ss(ss.modu)
  );

  // output divider by count and prescale
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_cnt_reg <= '0;
      div_out_reg <= 4'h0;
    end else begin
      for (int i = 0; i < rsd_pkg::NUM_BANK; i++) begin
        if (bank_s2[i] && !bank_q[i]) begin
          // Divide by two toggles every edge, else every count plus two edges
          if (!odiv_reg[i][rsd_pkg::ODIV_PM_BIT] ||
              div_cnt_reg[i] >= 8'({1'b0, odiv_reg[i][6:0]} + 8'h01)) begin
            div_cnt_reg[i] <= 8'h00;
            div_out_reg[i] <= ~div_out_reg[i];
          end else begin
            div_cnt_reg[i] <= 8'(div_cnt_reg[i] + 8'h01);
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bank_out_reg <= 4'h0;
      bank_en_n_reg <= 4'hF;
    end else begin
      for (int i = 0; i < rsd_pkg::NUM_BANK; i++) begin
        if (odiv_reg[i][6:0] == rsd_pkg::Q_ALL_ONES) begin
          if (odiv_reg[i][rsd_pkg::ODIV_PM_BIT]) begin
            bank_out_reg[i] <= bank_s2[i];
            bank_en_n_reg[i] <= 1'b0;
          end else begin
            bank_out_reg[i] <= (odiv_reg[i][rsd_pkg::ODIV_OEM_LSB +: 2] == rsd_pkg::OEM_HIGH);
            bank_en_n_reg[i] <= (odiv_reg[i][rsd_pkg::ODIV_OEM_LSB +: 2] != rsd_pkg::OEM_LOW) &&
              (odiv_reg[i][rsd_pkg::ODIV_OEM_LSB +: 2] != rsd_pkg::OEM_HIGH);
          end
        end else begin
          bank_out_reg[i] <= div_out_reg[i];
          bank_en_n_reg[i] <= 1'b0;
        end
      end
    end
  end
  assign bank_out = bank_out_reg;
  assign bank_out_en_n = bank_en_n_reg;
endmodule

//--- verif/rsd_ref_src.sv
// Model of the two redundant reference clock sources
`timescale 1ns/1ps
module rsd_ref_src #(
  parameter int XHALF = 3,
  parameter int CHALF = 5
) (
  // Clock and run controls
  input wire logic clk,
  input wire logic xin_run,
  input wire logic clkin_run,
  // Reference pins
  output logic xin_ref,
  output logic clkin
);
  int xc = 0; // Primary phase count
  int cc = 0; // Secondary phase count
  // Both pins start low
  initial begin
    xin_ref = 1'b0;
    clkin = 1'b0;
  end
  always @(posedge clk) begin
    xc <= (xc == XHALF - 1) ? 0 : xc + 1;
    cc <= (cc == CHALF - 1) ? 0 : cc + 1;
    // A stopped source parks low, like a pulled-down dead input
    if (!xin_run) xin_ref <= 1'b0;
    else if (xc == XHALF - 1) xin_ref <= ~xin_ref;
    if (!clkin_run) clkin <= 1'b0;
    else if (cc == CHALF - 1) clkin <= ~clkin;
  end
endmodule

//--- verif/rsd_top_asserts.sv
// Port checker for the switchover, divider and spread block
`timescale 1ns/1ps
module rsd_top_asserts (
  // Clock and reset
  input logic clk,
  input logic nrst,
  // Bus
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  // Outputs watched
  input logic ref_out,
  input logic pfd_tick,
  input logic [3:0][13:0] pll_fb_total,
  input logic [9:0] ss_point,
  input logic [3:0] bank_out_en_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved");
  a_fb_plain: assert property (pll_fb_total[1][13:12] == 2'h0 &&
    pll_fb_total[2][13:12] == 2'h0 && pll_fb_total[3][13:12] == 2'h0)
    else $error("feedback too wide");
  a_tick_pulse: assert property (pfd_tick |=> !pfd_tick)
    else $error("tick too long");
  a_reset_quiet: assert property ($rose(nrst) |-> !wb_ack_o && !pfd_tick && ss_point == 10'h000)
    else $error("outputs busy after reset");
  a_en_by_write: assert property ($changed(bank_out_en_n) |-> $past(wb_ack_o) ||
    $past(wb_ack_o, 2) || !$past(nrst, 2) || !$past(nrst, 3) || !$past(nrst, 4))
    else $error("enable moved alone");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_tick: cover property (pfd_tick);
  c_ref: cover property ($rose(ref_out));
endmodule
bind rsd_top rsd_top_asserts u_chk (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ref_out(ref_out), .pfd_tick(pfd_tick), .pll_fb_total(pll_fb_total),
  .ss_point(ss_point), .bank_out_en_n(bank_out_en_n));

//--- verif/testbench.sv
// Self-checking bench for the switchover, divider and spread block
`timescale 1ns/1ps
module testbench;
  typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} rsd_row_t;
  logic clk, nrst, cyc, stb, we, sel_pin, xrun, crun, ack, ref_out, tick, xin, cin;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0][6:0] rdiv;
  logic [3:0][13:0] fbt;
  logic [9:0] pt, pprev;
  logic [3:0] bclk, bout, ben_n;
  logic rprev, bprev;
  logic signed [9:0] mx, mn;
  int err_count = 0, checks_done = 0, cycles = 0, ref_rises = 0, bank_rises = 0;
  int hi_run = 0, min_hi = 99, gap = 0, since = 0, lsb0 = 0;
  // Register rows: writes interleaved with reads, reads with expected words
  rsd_row_t rows[13] = '{'{1, 8'h04, 32'h0030_1601, 0}, '{0, 8'h04, 0, 32'h0030_1601},
    '{0, 8'h34, 0, 32'h30}, '{1, 8'h34, 32'hFFFF_FFFF, 0}, '{0, 8'h34, 0, 32'h30},
    '{1, 8'h08, 32'h000A_BC7F, 0}, '{0, 8'h38, 0, 32'hABC}, '{1, 8'h0C, 32'h0050_0A05, 0},
    '{0, 8'h3C, 0, 32'h00A}, '{0, 8'h18, 0, 32'h7F}, '{0, 8'hFC, 0, 32'h0},
    '{1, 8'h04, 32'h0000_1601, 0}, '{0, 8'h34, 0, 32'h2C}};
  logic [31:0] odv[3] = '{32'h0000_00FF, 32'h0000_0000, 32'h0000_0081};
  int odx[3] = '{24, 12, 4};
  rsd_top dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .xin_ref(xin), .clkin(cin), .ref_select_pin(sel_pin), .ref_out(ref_out),
    .pfd_tick(tick), .pll_ref_div(rdiv), .pll_fb_total(fbt), .ss_point(pt),
    .bank_clk_in(bclk), .bank_out(bout), .bank_out_en_n(ben_n));
  rsd_ref_src src (.clk(clk), .xin_run(xrun), .clkin_run(crun), .xin_ref(xin), .clkin(cin));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Slow bank clocks and the hang guard
  always @(posedge clk) begin
    cycles++;
    bclk <= {4{cycles[2]}};
    if (cycles >= 60000) begin
      err_count++;
      end_sim;
    end
  end
  // Edge counts, shortest high pulse, modulation extremes and step spacing
  always @(posedge clk) begin
    if (ref_out && !rprev) ref_rises++;
    if (bout[0] && !bprev) bank_rises++;
    if (ref_out) hi_run++;
    else begin
      if (hi_run > 0 && hi_run < min_hi) min_hi = hi_run;
      hi_run = 0;
    end
    if (pt !== pprev) begin
      gap = since;
      since = 0;
    end
    if (tick) since++;
    if ($signed(pt) > mx) mx = pt;
    if ($signed(pt) < mn) mn = pt;
    rprev = ref_out;
    bprev = bout[0];
    pprev = pt;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // Classic single cycle; held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) chk(0, 1, "no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Rising edges in a window, one edge of phase slack
  task automatic rate(input int n, input int e, input logic bank, input string m);
    int r0;
    r0 = bank ? bank_rises : ref_rises;
    repeat (n) @(posedge clk);
    r0 = (bank ? bank_rises : ref_rises) - r0;
    chk(r0 >= e - 1 && r0 <= e + 1, 1, m);
  endtask
  task automatic stat(input int b, input logic e, input string m);
    bus(0, 8'h14, 0);
    chk(q[b], e, m);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    nrst = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; sel_pin = 0; xrun = 1; crun = 1;
    bclk = 0; mx = 0; mn = 0; pprev = 0; rprev = 0; bprev = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk({bout[0], ben_n[0]}, 0, "reset bank low");
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) chk(q, rows[i].e, "register row");
    end
    chk(fbt[0], 14'h2C, "even total");
    chk(rdiv[1], 7'h7F, "ref div");
    for (int lv = 0; lv < 3; lv++) begin
      bus(1, 8'h18, 32'h7F | (lv << 8));
      repeat (4) @(posedge clk);
      chk(ben_n[0], lv[1], "disabled enable");
      if (lv < 2) chk(bout[0], lv[0], "disabled level");
    end
    for (int i = 0; i < 3; i++) begin
      bus(1, 8'h18, odv[i]);
      repeat (16) @(posedge clk);
      rate(192, odx[i], 1, "bank divide");
    end
    rate(120, 20, 0, "manual primary");
    @(negedge clk) min_hi = 99;
    @(posedge clk) sel_pin <= 1'b1;
    repeat (20) @(posedge clk);
    rate(120, 12, 0, "manual secondary");
    chk(min_hi >= 3, 1, "switch pulse");
    bus(1, 8'h00, 32'h04);
    rate(120, 20, 0, "swapped primary");
    @(posedge clk) sel_pin <= 1'b0;
    bus(1, 8'h00, 32'h0A);
    @(posedge clk) xrun <= 1'b0;
    repeat (60) @(posedge clk);
    stat(0, 1, "auto move");
    stat(2, 1, "absent flag");
    rate(120, 12, 0, "auto secondary");
    @(posedge clk) xrun <= 1'b1;
    repeat (60) @(posedge clk);
    stat(0, 1, "no revert");
    bus(1, 8'h00, 32'h0B);
    repeat (60) @(posedge clk);
    stat(0, 0, "revert");
    bus(1, 8'h00, 32'h02);
    @(posedge clk) xrun <= 1'b0;
    repeat (60) @(posedge clk);
    stat(0, 0, "auto needs clocked pin");
    @(posedge clk) xrun <= 1'b1;
    bus(1, 8'h00, 32'h00);
    // add value set; deltas 1 and 2 under headroom, offset 5
    bus(1, 8'h04, 32'h0030_1601);
    bus(1, 8'h28, 32'h0000_0500);
    bus(1, 8'h2C, 32'h0000_0021);
    repeat (10) @(posedge clk);
    chk(pt, 5, "idle point");
    stat(3, 0, "spread off");
    bus(1, 8'h28, 32'h0000_0515);
    repeat (200) @(posedge clk);
    @(negedge clk) mx = -512;
    mn = 511;
    repeat (400) @(posedge clk);
    chk(mx, 8, "peak");
    chk(mn, 2, "trough");
    chk(gap, 7, "step ticks");
    stat(3, 1, "spread on");
    bus(1, 8'h28, 32'h0002_0515);
    repeat (100) @(posedge clk);
    @(negedge clk) mx = -512;
    mn = 511;
    repeat (400) @(posedge clk);
    chk(mx, 11, "double peak");
    chk(mn, -1, "double trough");
    // Odd offset plus even doubled sum keeps the LSB set unless dither flips it
    for (int d = 0; d < 2; d++) begin
      bus(1, 8'h28, 32'h0002_0515 | (d << 16));
      lsb0 = 0;
      repeat (200) begin
        @(posedge clk);
        if (pt[0] !== 1'b1) lsb0++;
      end
      chk(lsb0 > 0, d, "dither lsb");
    end
    // Reference divider of two halves the tick rate
    bus(1, 8'h04, 32'h0030_1602);
    lsb0 = 0;
    repeat (120) begin
      @(posedge clk);
      if (tick) lsb0++;
    end
    chk(lsb0 >= 9 && lsb0 <= 11, 1, "tick rate");
    end_sim;
  end
endmodule
